// ===== lbx_consts.vh
// constants for the literal and bit operation execute block
`ifndef LBX_CONSTS_VH
`define LBX_CONSTS_VH
// ==========================================================================
// opcode fields of the 14-bit instruction word
`define LBX_OPW        14
`define LBX_ADDR_LSB   0
`define LBX_ADDR_W     7
`define LBX_DEST_POS   7
`define LBX_BIT_LSB    7
`define LBX_BIT_W      3
`define LBX_LIT_W      8
// ==========================================================================
// opcode patterns
`define LBX_ADDREG_HI  6'h07
`define LBX_ANDREG_HI  6'h05
`define LBX_BITOP_HI   2'h1
`define LBX_BCF_SUB    2'h0
`define LBX_BSF_SUB    2'h1
`define LBX_BTC_SUB    2'h2
`define LBX_BTS_SUB    2'h3
`define LBX_ADDLIT_HI  5'h1f
`define LBX_ANDLIT_HI  6'h39
`define LBX_WDCLR_OP   14'h0064
`define LBX_NOP_OP     14'h0000
// ==========================================================================
// reset values
`define LBX_W_RST      8'h00
`define LBX_FLAG_RST   1'h0
`define LBX_STAT_RST   1'h1
`define LBX_WDT_ZERO   8'h00
`endif

// ===== lbx_alu.v
// adder and logic unit for the execute block
`timescale 1ns/1ps
module lbx_alu (
	input  wire [7:0] opA,
	input  wire [7:0] opB,
	input  wire       doAnd,
	output wire [7:0] result,
	output wire       carryOut,
	output wire       nibbleCarry,
	output wire       zeroOut
);
	wire [8:0] sum;
	wire [4:0] low;
	assign sum         = {1'b0, opA} + {1'b0, opB};
	assign low         = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
	assign result      = doAnd ? (opA & opB) : sum[7:0];
	assign carryOut    = sum[8];          // RULE14
	assign nibbleCarry = low[4];          // RULE14
	assign zeroOut     = (result == 8'h00); // RULE14
endmodule

// ===== lbx_execute.v
// execute stage for add, and, bit and watchdog clear operations
//
// What this block does
// RULE1 - add_immediate_op adds literal to working register, result to W, flags C DC Z.
// RULE2 - add_register_op adds W and file register at 7-bit address, flags C DC Z.
// RULE3 - register ops: destination bit 0 writes W, 1 writes file register.
// RULE4 - and_immediate_op ANDs literal with W into W, only zero flag changes.
// RULE5 - and_register_op ANDs W with file register, only zero flag, chosen destination.
// RULE6 - bit_clear_op clears the indexed bit of the file register, flags unchanged.
// RULE7 - bit_set_op sets the indexed bit of the file register, flags unchanged.
// RULE8 - skip_if_bit_clear_op on a zero bit discards next, runs a no-op instead.
// RULE9 - skip_if_bit_set_op on a one bit discards next, runs a no-op instead.
// RULE10 - watchdog_clear_op zeroes watchdog counter and its prescaler.
// RULE11 - watchdog_clear_op sets expired and power-down flags (active low) to one.
// RULE12 - a true conditional test takes two cycles, second is a no-op.
// RULE13 - read-modify-write of a port register reads pin levels, not latch.
// RULE14 - carry from bit 7, nibble carry from bit 3, zero when result zero.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "lbx_consts.vh"
module lbx_execute (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        instrValid,
	input  wire [13:0] instr,
	input  wire [7:0]  fileRdata,
	input  wire        fileIsPort,
	input  wire [7:0]  portPins,
	output reg  [6:0]  fileAddr,
	output reg  [7:0]  fileWdata,
	output reg         fileWe,
	output reg  [7:0]  wReg,
	output reg         carryFlag,
	output reg         nibbleCarryFlag,
	output reg         zeroFlag,
	output reg         watchdogExpiredFlagN,
	output reg         powerDownFlagN,
	output reg         watchdogClear,
	output reg         skipActive,
	output reg         flushFetch
);
	// ======================================================================
	// pin synchroniser: pins come from outside the clock domain
	reg  [7:0] pinMeta;
	reg  [7:0] pinSync;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta <= 8'h00;
			pinSync <= 8'h00;
		end else begin
			pinMeta <= portPins;
			pinSync <= pinMeta;
		end
	end
	// ======================================================================
	// decode
	wire [6:0] addr;
	wire       dest;
	wire [2:0] bitSel;
	wire [7:0] lit;
	wire       isAddReg;
	wire       isAndReg;
	wire       isBitOp;
	wire [1:0] bitSub;
	wire       isAddLit;
	wire       isAndLit;
	wire       isWdClr;
	wire [7:0] operand;
	wire       selBit;
	wire [7:0] bitMask;
	assign addr     = instr[`LBX_ADDR_LSB +: `LBX_ADDR_W];
	assign dest     = instr[`LBX_DEST_POS];
	assign bitSel   = instr[`LBX_BIT_LSB +: `LBX_BIT_W];
	assign lit      = instr[`LBX_LIT_W-1:0];
	assign isAddReg = (instr[13:8] == `LBX_ADDREG_HI);
	assign isAndReg = (instr[13:8] == `LBX_ANDREG_HI);
	assign isBitOp  = (instr[13:12] == `LBX_BITOP_HI);
	assign bitSub   = instr[11:10];
	assign isAddLit = (instr[13:9] == `LBX_ADDLIT_HI);
	assign isAndLit = (instr[13:8] == `LBX_ANDLIT_HI);
	assign isWdClr  = (instr == `LBX_WDCLR_OP);
	// port reads take the synchronised pin levels
	assign operand  = fileIsPort ? pinSync : fileRdata; // RULE13
	assign selBit   = operand[bitSel];
	assign bitMask  = 8'h01 << bitSel;
	// ======================================================================
	// arithmetic
	wire       useLit;
	wire       doAnd;
	wire [7:0] aluOut;
	wire       aluC;
	wire       aluDc;
	wire       aluZ;
	assign useLit = isAddLit | isAndLit;
	assign doAnd  = isAndLit | isAndReg;
	lbx_alu uAlu (
		.opA        (wReg),
		.opB        (useLit ? lit : operand),
		.doAnd      (doAnd),
		.result     (aluOut),
		.carryOut   (aluC),
		.nibbleCarry(aluDc),
		.zeroOut    (aluZ)
	);
	// ======================================================================
	// execute; an instruction arriving during a skip slot runs as a no-op
	wire live;
	wire skipTrue;
	assign live     = instrValid & ~skipActive;
	assign skipTrue = isBitOp & ((bitSub == `LBX_BTC_SUB & ~selBit) | // RULE8
	                  (bitSub == `LBX_BTS_SUB & selBit)); // RULE9
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fileAddr             <= 7'h00;
			fileWdata            <= 8'h00;
			fileWe               <= 1'b0;
			wReg                 <= `LBX_W_RST;
			carryFlag            <= `LBX_FLAG_RST;
			nibbleCarryFlag      <= `LBX_FLAG_RST;
			zeroFlag             <= `LBX_FLAG_RST;
			watchdogExpiredFlagN <= `LBX_STAT_RST;
			powerDownFlagN       <= `LBX_STAT_RST;
			watchdogClear        <= 1'b0;
			skipActive           <= 1'b0;
			flushFetch           <= 1'b0;
		end else begin
			fileWe        <= 1'b0;
			watchdogClear <= 1'b0;
			flushFetch    <= 1'b0;
			// the skip slot lasts exactly one cycle, the second of the test
			skipActive    <= live & skipTrue; // RULE12
			if (live) begin
				fileAddr <= addr;
				if (skipTrue) begin
					flushFetch <= 1'b1; // RULE8 RULE9
				end
				if (isAddLit) begin
					wReg            <= aluOut; // RULE1
					carryFlag       <= aluC;
					nibbleCarryFlag <= aluDc;
					zeroFlag        <= aluZ;
				end
				if (isAndLit) begin
					wReg     <= aluOut; // RULE4
					zeroFlag <= aluZ;
				end
				if (isAddReg | isAndReg) begin
					if (dest) begin
						fileWdata <= aluOut; // RULE3
						fileWe    <= 1'b1;
					end else begin
						wReg <= aluOut; // RULE3
					end
					zeroFlag <= aluZ; // RULE5
					if (isAddReg) begin
						carryFlag       <= aluC; // RULE2
						nibbleCarryFlag <= aluDc;
					end
				end
				if (isBitOp & bitSub == `LBX_BCF_SUB) begin
					fileWdata <= operand & ~bitMask; // RULE6
					fileWe    <= 1'b1;
				end
				if (isBitOp & bitSub == `LBX_BSF_SUB) begin
					fileWdata <= operand | bitMask; // RULE7
					fileWe    <= 1'b1;
				end
				if (isWdClr) begin
					watchdogClear        <= 1'b1; // RULE10
					watchdogExpiredFlagN <= 1'b1; // RULE11
					powerDownFlagN       <= 1'b1; // RULE11
				end
			end
		end
	end
endmodule

// ===== lbx_execute_chk.sv
// assertion checker for the execute block
`timescale 1ns/1ps
`include "lbx_consts.vh"
module lbx_execute_chk (
	input wire        mclk,
	input wire        sys_rst,
	input wire        instrValid,
	input wire [13:0] instr,
	input wire [7:0]  fileRdata,
	input wire        fileIsPort,
	input wire [7:0]  fileWdata,
	input wire        fileWe,
	input wire [7:0]  wReg,
	input wire        carryFlag,
	input wire        zeroFlag,
	input wire        watchdogExpiredFlagN,
	input wire        powerDownFlagN,
	input wire        watchdogClear,
	input wire        skipActive,
	input wire        flushFetch
);
	// ==========
	// properties
	wire taken = instrValid && !skipActive;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_status_stay_set: assert property (watchdogExpiredFlagN && powerDownFlagN)
		else $error("status flags not high");
	a_wdog_clear_pulse: assert property (taken && instr == `LBX_WDCLR_OP |=> watchdogClear)
		else $error("watchdog clear missing");
	a_skip_on_clear: assert property (taken && instr[13:10] == 4'h6 && !fileIsPort
		&& !fileRdata[instr[9:7]] |=> skipActive && flushFetch) else $error("no skip on clear");
	a_skip_on_set: assert property (taken && instr[13:10] == 4'h7 && !fileIsPort
		&& fileRdata[instr[9:7]] |=> skipActive && flushFetch) else $error("no skip on set");
	a_skip_one_cycle: assert property (skipActive |=> !skipActive && !fileWe)
		else $error("skip cycle not a no-op");
	a_bit_clear_data: assert property (taken && instr[13:10] == 4'h4 && !fileIsPort |=> fileWe
		&& fileWdata == ($past(fileRdata) & ~(8'h01 << $past(instr[9:7])))) else $error("bad clear");
	a_bit_op_flags: assert property (taken && instr[13:11] == 3'h2 |=> $stable(carryFlag)
		&& $stable(zeroFlag)) else $error("bit op changed flags");
	a_add_lit_sum: assert property (taken && instr[13:9] == 5'h1f
		|=> wReg == 8'($past(wReg) + $past(instr[7:0]))) else $error("bad literal add");
	cover property (taken && instr == `LBX_WDCLR_OP);
	cover property (skipActive);
	cover property (fileWe);
endmodule
bind lbx_execute lbx_execute_chk chk_u (.mclk(mclk), .sys_rst(sys_rst), .instrValid(instrValid),
	.instr(instr), .fileRdata(fileRdata), .fileIsPort(fileIsPort), .fileWdata(fileWdata),
	.fileWe(fileWe), .wReg(wReg), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
	.watchdogExpiredFlagN(watchdogExpiredFlagN), .powerDownFlagN(powerDownFlagN),
	.watchdogClear(watchdogClear), .skipActive(skipActive), .flushFetch(flushFetch));

// ===== test_literal_bit_op_execute.sv
// self-checking bench for the execute block
`timescale 1ns/1ps
module test_literal_bit_op_execute;
	reg          mclk = 1'b0, sys_rst = 1'b1, instrValid = 1'b0, fileIsPort = 1'b0;
	reg  [13:0]  instr = 14'h0000;
	reg  [7:0]   fileRdata = 8'h00, portPins = 8'h00;
	wire [6:0]   fileAddr;
	wire [7:0]   fileWdata, wReg;
	wire         fileWe, carryFlag, nibbleCarryFlag, zeroFlag, watchdogExpiredFlagN;
	wire         powerDownFlagN, watchdogClear, skipActive, flushFetch;
	int          n_mismatch = 0, checks = 0, kd = 0, s, op, bx, w = 0, res, wdat, fa;
	bit          c = 0, dc = 0, z = 0, sk = 0, we, wd;
	logic [13:0] base [9] = '{14'h0700, 14'h0500, 14'h1000, 14'h1400, 14'h1800, 14'h1c00,
		14'h3e00, 14'h3900, 14'h0064};
	logic [13:0] msk [9] = '{14'h00ff, 14'h00ff, 14'h03ff, 14'h03ff, 14'h03ff, 14'h03ff,
		14'h01ff, 14'h00ff, 14'h0000};
	always #10 mclk = ~mclk;
	lbx_execute dut_u (.mclk(mclk), .sys_rst(sys_rst), .instrValid(instrValid), .instr(instr),
		.fileRdata(fileRdata), .fileIsPort(fileIsPort), .portPins(portPins),
		.fileAddr(fileAddr), .fileWdata(fileWdata), .fileWe(fileWe), .wReg(wReg),
		.carryFlag(carryFlag), .nibbleCarryFlag(nibbleCarryFlag), .zeroFlag(zeroFlag),
		.watchdogExpiredFlagN(watchdogExpiredFlagN), .powerDownFlagN(powerDownFlagN),
		.watchdogClear(watchdogClear), .skipActive(skipActive), .flushFetch(flushFetch));
	// ==========
	// helpers
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// reference model, run with the values sampled at the edge
	task model;
		we = 0;
		wd = 0;
		op = fileIsPort ? portPins : fileRdata;
		bx = instr[9:7];
		fa = instr[6:0];
		if (instrValid && !sk) begin
			s = kd < 2 ? op : instr[7:0];
			res = (kd == 0 || kd == 6) ? (w + s) % 256 : w & s;
			if (kd == 0 || kd == 6) begin
				c = (w + s) > 255;
				dc = (w % 16 + s % 16) > 15;
			end
			if (kd < 2 || kd == 6 || kd == 7) begin
				z = res == 0;
				we = kd < 2 && instr[7];
				if (we) wdat = res;
				else w = res;
			end
			if (kd == 2 || kd == 3) begin
				we = 1;
				wdat = kd == 2 ? op & ~(1 << bx) : op | (1 << bx);
			end
			wd = kd == 8;
			sk = (kd == 4 && !op[bx]) || (kd == 5 && op[bx]);
		end else
			sk = 0;
	endtask
	// ==========
	// stimulus
	initial begin
		s = $urandom(32'h21ac82e1);
		portPins <= $urandom; // held steady so the two-flop lag cannot matter
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 3000; i++) begin
			@(posedge mclk);
			model;
			kd = $urandom % 9;
			instr <= base[kd] | (msk[kd] & 14'($urandom));
			instrValid <= $urandom % 8 != 0;
			fileRdata <= $urandom;
			fileIsPort <= (kd == 2 || kd == 3) && $urandom % 2;
			#1;
			chk("wReg", w, wReg);
			chk("flags", {c, dc, z}, {carryFlag, nibbleCarryFlag, zeroFlag});
			chk("fileWe", we, fileWe);
			if (we) chk("fileWdata", wdat, fileWdata);
			if (we) chk("fileAddr", fa, fileAddr);
			chk("wdog", {wd, 2'b11}, {watchdogClear, watchdogExpiredFlagN, powerDownFlagN});
			chk("skip", {sk, sk}, {skipActive, flushFetch});
		end
		end_sim;
	end
endmodule
